//--- ilen_checker.sv
`timescale 1ns/1ps
`default_nettype none
module ilen_checker
  import ilen_pkg::*;
#(
  parameter int N = ILEN_NSRC,
  parameter int IDW = ILEN_IDW,
  parameter int AW = ILEN_ADDRW,
  parameter int DW = ILEN_DATAW
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [AW-1:0] reg_addr,
  input wire logic reg_rd,
  input wire logic [DW-1:0] reg_rdata,
  input wire logic [N-1:0] src_req,
  input wire logic cpu_accept,
  input wire logic enable_irq_instruction,
  input wire logic cpu_return,
  input wire logic cpu_return_imf,
  input wire logic irq_req,
  input wire logic [IDW-1:0] irq_id,
  input wire logic irq_nonmaskable,
  input wire logic master_irq_enable
);
  // ------
  // Checks
  // ------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);
  accept_drop_a: assert property (cpu_accept |=> !irq_req)
    else $error("request kept after accept");
  accept_mask_a: assert property (
    cpu_accept |=> !master_irq_enable) else $error("master kept");
  ei_set_a: assert property (
    enable_irq_instruction && !cpu_accept && !cpu_return
    |=> master_irq_enable) else $error("master not set");
  ret_restore_a: assert property (
    cpu_return && !cpu_accept
    |=> master_irq_enable == $past(cpu_return_imf))
    else $error("master not restored");
  wdt_pass_a: assert property (
    src_req[ILEN_WDT_SRC] ##1 !cpu_accept |=> irq_req && irq_nonmaskable)
    else $error("watchdog not presented");
  master_gate_a: assert property (
    irq_req && !$past(master_irq_enable) |-> irq_nonmaskable)
    else $error("maskable passed with master off");
  nm_id_a: assert property (
    irq_nonmaskable |-> irq_req && irq_id == ILEN_WDT_ID)
    else $error("wrong nonmaskable id");
  low_bits_a: assert property (
    reg_rd && reg_addr == ILEN_PENDING_LOW |=> reg_rdata[2:0] == 3'h0)
    else $error("unused latch bits set");
endmodule
bind ilen_unit ilen_checker #(.N(N), .IDW(IDW), .AW(AW), .DW(DW))
  ilen_checker_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .src_req(src_req),
  .cpu_accept(cpu_accept), .cpu_return(cpu_return),
  .enable_irq_instruction(enable_irq_instruction),
  .cpu_return_imf(cpu_return_imf), .irq_req(irq_req),
  .irq_id(irq_id), .irq_nonmaskable(irq_nonmaskable),
  .master_irq_enable(master_irq_enable));
`default_nettype wire

//--- ilen_cpu_model.sv
`timescale 1ns/1ps
`default_nettype none
module ilen_cpu_model
  import ilen_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic go,
  input wire logic [1:0] lag,
  input wire logic irq_req,
  input wire logic [ILEN_IDW-1:0] irq_id,
  input wire logic stack_imf,
  output logic cpu_accept,
  output logic [ILEN_IDW-1:0] cpu_accept_id,
  output logic cpu_return_imf
);
  // ----------
  // Core side
  // ----------
  logic fire;
  logic [1:0] cnt;
  // Gated by the live request, so a dropped request is never taken
  assign cpu_accept = fire & irq_req;
  assign cpu_accept_id = irq_id;
  always @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      fire <= 1'h0;
      cnt <= 2'h0;
      cpu_return_imf <= 1'h0;
    end
    else
    begin
      // One stack level only; nesting is not modelled
      if (cpu_accept)
        cpu_return_imf <= stack_imf;
      cnt <= (go && irq_req && !fire) ? cnt + 2'h1 : 2'h0;
      fire <= go && !cpu_accept && (fire || (irq_req && cnt >= lag));
    end
  end
endmodule
`default_nettype wire

//--- ilen_latch_bank.sv
`timescale 1ns/1ps
`default_nettype none

module ilen_latch_bank
  import ilen_pkg::*;
#(
  parameter int N = ILEN_NSRC,
  parameter logic [31:0] PRESENT = ILEN_LATCH_MASK
)
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic [N-1:0] set_req,
  input wire logic [N-1:0] clr_req,
  output logic [N-1:0] q
);

  // ------------------------------------------------------------------
  // One latch per source whose PRESENT bit is set
  // ------------------------------------------------------------------
  genvar i;
  generate
    for (i = 0; i < N; i = i + 1)
    begin : g_latch
      if (PRESENT[i])
      begin : g_present
        // Own flop per bit so q has only continuous drivers
        logic bit_q;
        always_ff @(posedge clk or negedge nrst)
        begin
          if (!nrst)
            bit_q <= ILEN_PENDING_RESET[i];
          else if (set_req[i])
            bit_q <= 1'b1;
          else if (clr_req[i])
            bit_q <= 1'b0;
        end
        assign q[i] = bit_q;
      end
      else
      begin : g_absent
        // No latch: software and undefined-instruction slots, and the positions above source 25
        assign q[i] = 1'b0;
      end
    end
  endgenerate

endmodule

`default_nettype wire

//--- ilen_pkg.sv
package ilen_pkg;

  // ------------------------------------------------------------------
  // Geometry
  // ------------------------------------------------------------------
  localparam int ILEN_NSRC = 32;
  localparam int ILEN_IDW = 5;
  localparam int ILEN_ADDRW = 12;
  localparam int ILEN_DATAW = 8;
  localparam int ILEN_NBYTES = 4;

  // ------------------------------------------------------------------
  // Register addresses
  // ------------------------------------------------------------------
  localparam logic [11:0] ILEN_ENABLE_LOW = 12'h03A;
  localparam logic [11:0] ILEN_ENABLE_HIGH = 12'h03B;
  localparam logic [11:0] ILEN_ENABLE_EXT = 12'h03C;
  localparam logic [11:0] ILEN_ENABLE_TOP = 12'h03D;
  localparam logic [11:0] ILEN_PENDING_LOW = 12'hFE0;
  localparam logic [11:0] ILEN_PENDING_HIGH = 12'hFE1;
  localparam logic [11:0] ILEN_PENDING_EXT = 12'hFE2;
  localparam logic [11:0] ILEN_PENDING_TOP = 12'hFE3;

  // ------------------------------------------------------------------
  // Source numbering and bit positions
  // ------------------------------------------------------------------
  localparam int ILEN_MASTER_BIT = 0;
  localparam int ILEN_WDT_SRC = 3;
  localparam int ILEN_FIRST_MASKABLE = 4;
  localparam int ILEN_LAST_SRC = 25;
  localparam logic [4:0] ILEN_WDT_ID = 5'h03;

  // Bits that own a latch (watchdog and maskable sources)
  localparam logic [31:0] ILEN_LATCH_MASK = 32'h03FF_FFF8;
  // Latch bits software may clear
  localparam logic [31:0] ILEN_CLEARABLE_MASK = 32'h03FF_FFF0;
  // Individual enable bits plus the master enable
  localparam logic [31:0] ILEN_ENABLE_MASK = 32'h03FF_FFF1;
  localparam logic [31:0] ILEN_MASKABLE_MASK = 32'h03FF_FFF0;

  // ------------------------------------------------------------------
  // Reset values
  // ------------------------------------------------------------------
  localparam logic [31:0] ILEN_PENDING_RESET = 32'h0000_0000;
  localparam logic [31:0] ILEN_ENABLE_RESET = 32'h0000_0000;
  localparam logic [7:0] ILEN_RDATA_RESET = 8'h00;
  localparam logic [4:0] ILEN_ID_RESET = 5'h00;

endpackage

//--- ilen_prio_pick.sv
`timescale 1ns/1ps
`default_nettype none

module ilen_prio_pick
  import ilen_pkg::*;
#(
  parameter int N = ILEN_NSRC,
  parameter int IDW = ILEN_IDW
)
(
  input wire logic [N-1:0] eligible,
  output logic any,
  output logic [IDW-1:0] id
);

  // ------------------------------------------------------------------
  // Lowest source number wins: it has the highest basic priority
  // ------------------------------------------------------------------
  always_comb
  begin
    any = 1'b0;
    id = '0;
    for (int k = N - 1; k >= 0; k = k - 1)
    begin
      if (eligible[k])
      begin
        any = 1'b1;
        id = IDW'(k);
      end
    end
  end

endmodule

`default_nettype wire

//--- ilen_unit.sv
`timescale 1ns/1ps
`default_nettype none

module ilen_unit
  import ilen_pkg::*;
#(
  parameter int N = ILEN_NSRC,
  parameter int IDW = ILEN_IDW,
  parameter int AW = ILEN_ADDRW,
  parameter int DW = ILEN_DATAW
)
(
  input wire logic clk,
  input wire logic nrst,
  // Register port
  input wire logic [AW-1:0] reg_addr,
  input wire logic [DW-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DW-1:0] reg_rdata,
  output logic reg_hit,
  // Sources
  input wire logic [N-1:0] src_req,
  // CPU core
  input wire logic cpu_accept,
  input wire logic [IDW-1:0] cpu_accept_id,
  input wire logic enable_irq_instruction,
  input wire logic disable_irq_instruction,
  input wire logic cpu_return,
  input wire logic cpu_return_imf,
  output logic irq_req,
  output logic [IDW-1:0] irq_id,
  output logic irq_nonmaskable,
  output logic master_irq_enable,
  output logic stack_imf
);

  // ------------------------------------------------------------------
  // Address decode
  // ------------------------------------------------------------------
  logic [ILEN_NBYTES-1:0] pend_sel;
  logic [ILEN_NBYTES-1:0] en_sel;
  logic any_sel;

  assign pend_sel[0] = (reg_addr == ILEN_PENDING_LOW);
  assign pend_sel[1] = (reg_addr == ILEN_PENDING_HIGH);
  assign pend_sel[2] = (reg_addr == ILEN_PENDING_EXT);
  assign pend_sel[3] = (reg_addr == ILEN_PENDING_TOP);
  assign en_sel[0] = (reg_addr == ILEN_ENABLE_LOW);
  assign en_sel[1] = (reg_addr == ILEN_ENABLE_HIGH);
  assign en_sel[2] = (reg_addr == ILEN_ENABLE_EXT);
  assign en_sel[3] = (reg_addr == ILEN_ENABLE_TOP);
  assign any_sel = (|pend_sel) | (|en_sel);

  // ------------------------------------------------------------------
  // Write strobes spread to full-width vectors
  // ------------------------------------------------------------------
  logic [N-1:0] wr_pend_bits;
  logic [N-1:0] wr_en_bits;
  logic [N-1:0] wdata_rep;

  genvar b;
  generate
    for (b = 0; b < ILEN_NBYTES; b = b + 1)
    begin : g_lane
      assign wr_pend_bits[b*DW +: DW] = {DW{reg_wr & pend_sel[b]}};
      assign wr_en_bits[b*DW +: DW] = {DW{reg_wr & en_sel[b]}};
      assign wdata_rep[b*DW +: DW] = reg_wdata;
    end
  endgenerate

  // ------------------------------------------------------------------
  // Pending latches
  // ------------------------------------------------------------------
  logic [N-1:0] pending;
  logic [N-1:0] sw_clear;
  logic [N-1:0] ack_clear;
  logic [N-1:0] accept_dec;
  logic [N-1:0] latch_set;

  always_comb
  begin
    accept_dec = '0;
    if (cpu_accept)
      accept_dec[cpu_accept_id] = 1'b1;
  end

  // Zero clears, one leaves the latch alone; watchdog is not clearable
  assign sw_clear = wr_pend_bits & ~wdata_rep & ILEN_CLEARABLE_MASK;
  assign ack_clear = accept_dec & ILEN_LATCH_MASK;
  assign latch_set = src_req & ILEN_LATCH_MASK;

  ilen_latch_bank #(
    .N(N),
    .PRESENT(ILEN_LATCH_MASK)
  ) u_latch (
    .clk(clk),
    .nrst(nrst),
    .set_req(latch_set),
    .clr_req(sw_clear | ack_clear),
    .q(pending)
  );

  // ------------------------------------------------------------------
  // Individual enables
  // ------------------------------------------------------------------
  logic [N-1:0] source_irq_enable;

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      source_irq_enable <= ILEN_ENABLE_RESET & ILEN_MASKABLE_MASK;
    else
    begin
      for (int k = 0; k < N; k = k + 1)
      begin
        if (wr_en_bits[k] && ILEN_MASKABLE_MASK[k])
          source_irq_enable[k] <= wdata_rep[k];
      end
    end
  end

  // ------------------------------------------------------------------
  // Master enable
  // ------------------------------------------------------------------
  logic next_master;

  // Acceptance outranks every other source of change
  always_comb
  begin
    next_master = master_irq_enable;
    if (cpu_accept)
      next_master = 1'b0;
    else if (cpu_return)
      next_master = cpu_return_imf;
    else if (enable_irq_instruction)
      next_master = 1'b1;
    else if (disable_irq_instruction)
      next_master = 1'b0;
    else if (wr_en_bits[ILEN_MASTER_BIT])
      next_master = reg_wdata[ILEN_MASTER_BIT];
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      master_irq_enable <= ILEN_ENABLE_RESET[ILEN_MASTER_BIT];
    else
      master_irq_enable <= next_master;
  end

  // Value the core pushes; tracks the flag before any clear
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      stack_imf <= ILEN_ENABLE_RESET[ILEN_MASTER_BIT];
    else
      stack_imf <= next_master;
  end

  // ------------------------------------------------------------------
  // Request gating and selection
  // ------------------------------------------------------------------
  logic [N-1:0] maskable_ok;
  logic [N-1:0] eligible;
  logic pick_any;
  logic [IDW-1:0] pick_id;

  assign maskable_ok = pending & source_irq_enable & ILEN_MASKABLE_MASK
    & {N{master_irq_enable}};
  // Watchdog skips both enable levels
  assign eligible = maskable_ok
    | (pending & ~ILEN_MASKABLE_MASK & ILEN_LATCH_MASK)
    | ~ILEN_LATCH_MASK & '0;

  ilen_prio_pick #(
    .N(N),
    .IDW(IDW)
  ) u_pick (
    .eligible(eligible & ~accept_dec),
    .any(pick_any),
    .id(pick_id)
  );

  // Dropped the cycle after accept so a stale request is never retaken
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      irq_req <= 1'b0;
      irq_id <= ILEN_ID_RESET;
      irq_nonmaskable <= 1'b0;
    end
    else
    begin
      irq_req <= pick_any & ~cpu_accept;
      irq_id <= pick_id;
      irq_nonmaskable <= pick_any & (pick_id == ILEN_WDT_ID);
    end
  end

  // ------------------------------------------------------------------
  // Read path
  // ------------------------------------------------------------------
  logic [N-1:0] pend_view;
  logic [N-1:0] en_view;
  logic [DW-1:0] next_rdata;

  // Unused positions, including bits 0-2 of the low latch byte
  assign pend_view = pending & ILEN_LATCH_MASK;
  assign en_view = (source_irq_enable & ILEN_MASKABLE_MASK)
    | {{(N-1){1'b0}}, master_irq_enable};

  always_comb
  begin
    next_rdata = '0;
    for (int k = 0; k < ILEN_NBYTES; k = k + 1)
    begin
      if (pend_sel[k])
        next_rdata = pend_view[k*DW +: DW];
      if (en_sel[k])
        next_rdata = en_view[k*DW +: DW];
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_rdata <= ILEN_RDATA_RESET;
    else if (reg_rd)
      reg_rdata <= next_rdata;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      reg_hit <= 1'b0;
    else
      reg_hit <= (reg_rd | reg_wr) & any_sel;
  end

endmodule

`default_nettype wire

//--- tb_interrupt_latch_enable_unit.sv
`timescale 1ns/1ps
`default_nettype none
module tb_interrupt_latch_enable_unit
  import ilen_pkg::*;
;
  // ------
  // Bench
  // ------
  logic clk = 0, nrst = 0, reg_wr = 0, reg_rd = 0, ei = 0, di = 0;
  logic ret = 0, go = 0, reg_hit, irq_req, irq_nm, mie, simf, acc, rimf;
  logic [1:0] lag = 0;
  logic [11:0] reg_addr = 0;
  logic [7:0] reg_wdata = 0, reg_rdata;
  logic [4:0] irq_id, acc_id;
  logic [31:0] src_req = 0, e_lat = 0, e_en = 0, v, m;
  int errors = 0, samples_checked = 0, seed = 74, i, k;
  ilen_unit ilen_unit_i (.clk(clk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .reg_hit(reg_hit), .src_req(src_req),
    .cpu_accept(acc), .cpu_accept_id(acc_id), .cpu_return(ret),
    .enable_irq_instruction(ei), .disable_irq_instruction(di),
    .cpu_return_imf(rimf), .irq_req(irq_req), .irq_id(irq_id),
    .irq_nonmaskable(irq_nm), .master_irq_enable(mie), .stack_imf(simf));
  ilen_cpu_model ilen_cpu_model_i (.clk(clk), .nrst(nrst), .go(go),
    .lag(lag), .irq_req(irq_req), .irq_id(irq_id), .stack_imf(simf),
    .cpu_accept(acc), .cpu_accept_id(acc_id), .cpu_return_imf(rimf));
  initial forever #25 clk = ~clk;
  task automatic chk(string n, logic [31:0] s, logic [31:0] e);
    samples_checked++;
    if (s !== e)
    begin
      errors++;
      $display("mismatch %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic close_out;
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(bit w, logic [11:0] a, logic [7:0] dt);
    @(posedge clk);
    #2 reg_addr = a;
    reg_wdata = dt;
    reg_wr = w;
    reg_rd = !w;
    @(posedge clk);
    #2 reg_wr = 0;
    reg_rd = 0;
  endtask
  task automatic wr(logic [11:0] a, logic [7:0] dt);
    k = 8 * (a[11] ? a - ILEN_PENDING_LOW : a - ILEN_ENABLE_LOW);
    bus(1, a, dt);
    if (a[11])
      e_lat[k+:8] &= dt | ~ILEN_CLEARABLE_MASK[k+:8];
    else
      e_en[k+:8] = dt & ILEN_ENABLE_MASK[k+:8];
  endtask
  task automatic wr_all(logic [11:0] a, logic [31:0] val);
    for (int j = 0; j < 4; j++)
      wr(12'(a + j), val[8*j+:8]);
  endtask
  task automatic check_all;
    m = e_lat & ILEN_LATCH_MASK;
    for (i = 0; i < 4; i++)
    begin
      bus(0, 12'(ILEN_PENDING_LOW + i), 0);
      chk("pending", {reg_hit, reg_rdata}, {1'b1, m[8*i+:8]});
      bus(0, 12'(ILEN_ENABLE_LOW + i), 0);
      chk("enable", {reg_hit, reg_rdata}, {1'b1, e_en[8*i+:8]});
    end
    bus(1, 12'h03E, 8'hFF);
    bus(0, 12'h03E, 8'h00);
    chk("unmapped", {reg_hit, reg_rdata}, 0);
  endtask
  task automatic raise(logic [31:0] s);
    @(posedge clk);
    #2 src_req = s;
    e_lat |= s & ILEN_LATCH_MASK;
    @(posedge clk);
    #2 src_req = 0;
  endtask
  task automatic pulse(ref logic s);
    @(posedge clk);
    #2 s = 1;
    @(posedge clk);
    #2 s = 0;
  endtask
  // Slow or prompt answers: the bench picks lag at random for the core model
  task automatic take(logic [4:0] e);
    lag = 2'($random(seed));
    go = 1;
    for (i = 0; i < 40 && acc !== 1'b1; i++)
      @(posedge clk) #2;
    chk("accept", acc, 1);
    if (acc !== 1'b1)
      close_out;
    chk("accept id", acc_id, e);
    chk("nonmaskable", irq_nm, e == ILEN_WDT_ID);
    @(posedge clk) #2;
    go = 0;
    e_lat[e] = 0;
    chk("master", mie, 0);
    pulse(ret);
    chk("master", mie, e_en[0]);
  endtask
  initial
  begin
    repeat (3) @(posedge clk);
    #2 nrst = 1;
    check_all;
    v = $random(seed);
    wr_all(ILEN_ENABLE_LOW, v);
    check_all;
    wr_all(ILEN_ENABLE_LOW, 0);
    $display("test enables done");
    raise($random(seed) | 8);
    check_all;
    wr_all(ILEN_PENDING_LOW, '1);
    check_all;
    wr_all(ILEN_PENDING_LOW, 0);
    check_all;
    take(ILEN_WDT_ID);
    check_all;
    @(posedge clk);
    #2 src_req = 32'h0000_0100;
    reg_addr = ILEN_PENDING_HIGH;
    reg_wdata = 8'h00;
    reg_wr = 1;
    @(posedge clk);
    #2 src_req = 0;
    reg_wr = 0;
    e_lat[8] = 1;
    check_all;
    wr(ILEN_PENDING_HIGH, 8'hFE);
    $display("test latches done");
    wr(ILEN_ENABLE_LOW, 8'h20);
    wr(ILEN_ENABLE_HIGH, 8'h02);
    raise(32'h0000_0260);
    repeat (4) @(posedge clk);
    #2 chk("blocked", irq_req, 0);
    pulse(ei);
    e_en[0] = 1;
    take(5'h05);
    take(5'h09);
    check_all;
    pulse(di);
    e_en[0] = 0;
    check_all;
    $display("test accept done");
    #2 nrst = 0;
    repeat (2) @(posedge clk);
    #2 nrst = 1;
    e_lat = 0;
    e_en = 0;
    check_all;
    $display("test reset done");
    close_out;
  end
endmodule
`default_nettype wire
